// ---- hdl/ibd_pkg.sv ----
`default_nettype none
package ibd_pkg;
  // register path addresses
  localparam logic [7:0] ADDR_INDEX = 8'hD0;
  localparam logic [7:0] ADDR_TAG = 8'hD1;
  localparam logic [7:0] ADDR_DATA = 8'hD2;
  localparam logic [7:0] ADDR_CSR = 8'hD3;
  localparam logic [7:0] ADDR_BRANCH = 8'hD4;
  // index register fields
  localparam int IDX_TAG_MSB = 31;
  localparam int IDX_TAG_LSB = 11;
  localparam int IDX_ROW_MSB = 10;
  localparam int IDX_ROW_LSB = 5;
  localparam int IDX_QUAD_MSB = 4;
  localparam int IDX_QUAD_LSB = 3;
  localparam int IDX_HALF_BIT = 2;
  // tag port layout: tag 31:11, tag parity 8, data parity 7:4, valid 3:0
  localparam logic [31:0] TAG_PORT_MASK = 32'hFFFFF9FF;
  // fetch unit control: cache enable
  localparam int CSR_ENABLE_BIT = 0;
  localparam logic CSR_ENABLE_RESET = 1'h0;
  // branch control fields
  localparam int BR_ALG_MSB = 31;
  localparam int BR_ALG_LSB = 16;
  localparam int BR_CMD_MSB = 8;
  localparam int BR_CMD_LSB = 6;
  localparam int BR_HIST_MSB = 3;
  localparam int BR_HIST_LSB = 0;
  localparam int CMD_FLUSH = 0;
  localparam int CMD_CLEAR = 1;
  localparam int CMD_LOAD = 2;
  // power-up prediction algorithm, same as microcode's first write
  localparam logic [15:0] ALG_RESET = 16'hFECA;
  localparam logic [3:0] HIST_NEUTRAL = 4'h4;
  // array geometry
  localparam int ROWS = 64;
  localparam int QUADS = 256;
  localparam int HIST_ENTRIES = 512;
endpackage : ibd_pkg
`default_nettype wire

// ---- hdl/ibd_regs.sv ----
`default_nettype none
module ibd_regs (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ipr_req_in,
  input wire logic ipr_write_in,
  input wire logic [7:0] ipr_addr_in,
  input wire logic [31:0] ipr_wdata_in,
  output logic ipr_ack_out,
  output logic [31:0] ipr_rdata_out,
  input wire logic parity_err_in,
  input wire logic [31:0] parity_err_vaddr_in,
  output logic icache_enable_out,
  input wire logic [3:0] branch_history_in,
  output logic predict_taken_out,
  input wire logic branch_resolve_in,
  input wire logic branch_mispredict_in,
  input wire logic context_flush_in,
  input wire logic [8:0] hist_lookup_in,
  output logic [3:0] hist_entry_out
);
  // access decode
  wire logic wr = ipr_req_in && ipr_write_in;
  wire logic rd = ipr_req_in && !ipr_write_in;
  wire logic hit_idx = ipr_addr_in == ibd_pkg::ADDR_INDEX;
  wire logic hit_tag = ipr_addr_in == ibd_pkg::ADDR_TAG;
  wire logic hit_data = ipr_addr_in == ibd_pkg::ADDR_DATA;
  wire logic hit_csr = ipr_addr_in == ibd_pkg::ADDR_CSR;
  wire logic hit_br = ipr_addr_in == ibd_pkg::ADDR_BRANCH;

  // index register state
  logic [20:0] err_tag_r; // read-only error tag
  logic [5:0] row_r; // array row
  logic [1:0] quad_r; // quadword in row
  logic half_r; // write-only half select
  logic enable_r; // cache enable from control register

  // arrays are only reachable while the cache is off, so fetch never races diagnostics
  wire logic arr_ok = !enable_r;
  wire logic [7:0] quad_idx = {row_r, quad_r};
  wire logic wr_tag = wr && hit_tag && arr_ok;
  wire logic wr_data = wr && hit_data;
  wire logic rd_data = rd && hit_data;
  wire logic wr_br = wr && hit_br;
  wire logic rd_br = rd && hit_br;
  wire logic [2:0] br_cmd = ipr_wdata_in[ibd_pkg::BR_CMD_MSB:ibd_pkg::BR_CMD_LSB];

  // index register: an error capture wins over a same-cycle software write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      err_tag_r <= 21'h0;
      row_r <= 6'h0;
      quad_r <= 2'h0;
    end else if (parity_err_in) begin
      err_tag_r <= parity_err_vaddr_in[ibd_pkg::IDX_TAG_MSB:ibd_pkg::IDX_TAG_LSB];
      row_r <= parity_err_vaddr_in[ibd_pkg::IDX_ROW_MSB:ibd_pkg::IDX_ROW_LSB];
      quad_r <= parity_err_vaddr_in[ibd_pkg::IDX_QUAD_MSB:ibd_pkg::IDX_QUAD_LSB];
    end else if (wr && hit_idx) begin
      row_r <= ipr_wdata_in[ibd_pkg::IDX_ROW_MSB:ibd_pkg::IDX_ROW_LSB];
      quad_r <= ipr_wdata_in[ibd_pkg::IDX_QUAD_MSB:ibd_pkg::IDX_QUAD_LSB];
    end
  end

  // half select is software only; errors leave it alone
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      half_r <= 1'h0;
    end else if (wr && hit_idx) begin
      half_r <= ipr_wdata_in[ibd_pkg::IDX_HALF_BIT];
    end
  end

  // fetch unit control register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      enable_r <= ibd_pkg::CSR_ENABLE_RESET;
    end else if (wr && hit_csr) begin
      enable_r <= ipr_wdata_in[ibd_pkg::CSR_ENABLE_BIT];
    end
  end
  assign icache_enable_out = enable_r;

  // tag array: unused bits 10:9 are dropped on write
  logic [31:0] tag_arr [0:ibd_pkg::ROWS-1];
  always_ff @(posedge clk_in) begin
    if (wr_tag) begin
      tag_arr[row_r] <= ipr_wdata_in & ibd_pkg::TAG_PORT_MASK;
    end
  end

  // data array with fill buffer and read-back holder
  logic [63:0] data_arr [0:ibd_pkg::QUADS-1];
  logic [31:0] fill_lo_r; // low half waiting for its partner
  logic [31:0] rd_hi_r; // upper half of last fetched quadword
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fill_lo_r <= 32'h0;
    end else if (wr_data && !half_r) begin
      fill_lo_r <= ipr_wdata_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (wr_data && half_r && arr_ok) begin
      data_arr[quad_idx] <= {ipr_wdata_in, fill_lo_r};
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_hi_r <= 32'h0;
    end else if (rd_data && !half_r && arr_ok) begin
      rd_hi_r <= data_arr[quad_idx][63:32];
    end
  end

  // branch guess unit: algorithm store
  logic [15:0] alg_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      alg_r <= ibd_pkg::ALG_RESET;
    end else if (wr_br) begin
      alg_r <= ipr_wdata_in[ibd_pkg::BR_ALG_MSB:ibd_pkg::BR_ALG_LSB];
    end
  end

  // command decode; undefined codes fall out of the same three terms
  wire logic do_flush = wr_br && br_cmd[ibd_pkg::CMD_FLUSH];
  wire logic do_clear = wr_br && br_cmd[ibd_pkg::CMD_CLEAR];
  wire logic do_load = wr_br && br_cmd[ibd_pkg::CMD_LOAD];

  // table address counter
  logic [8:0] ctr_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctr_r <= 9'h0;
    end else if (do_clear) begin
      ctr_r <= 9'h0;
    end else if (do_load || rd_br) begin
      ctr_r <= ctr_r + 9'h1; // natural 9-bit wrap
    end
  end

  // history table: per entry flops so a flush takes one cycle
  logic [3:0] hist_r [0:ibd_pkg::HIST_ENTRIES-1];
  genvar gi;
  generate
    for (gi = 0; gi < ibd_pkg::HIST_ENTRIES; gi++) begin : g_hist
      // a history write beats a flush on the addressed entry
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          hist_r[gi] <= ibd_pkg::HIST_NEUTRAL;
        end else if (do_load && ctr_r == 9'(gi)) begin
          hist_r[gi] <= ipr_wdata_in[ibd_pkg::BR_HIST_MSB:ibd_pkg::BR_HIST_LSB];
        end else if (do_flush || context_flush_in) begin
          hist_r[gi] <= ibd_pkg::HIST_NEUTRAL;
        end
      end
    end
  endgenerate

  // mispredict flag follows every resolved conditional branch
  logic mispredict_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mispredict_r <= 1'h0;
    end else if (branch_resolve_in) begin
      mispredict_r <= branch_mispredict_in;
    end
  end

  // prediction and lookup outputs, registered for timing
  logic predict_r;
  logic [3:0] lookup_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      predict_r <= 1'h0;
      lookup_r <= 4'h0;
    end else begin
      predict_r <= alg_r[branch_history_in];
      lookup_r <= hist_r[hist_lookup_in];
    end
  end
  assign predict_taken_out = predict_r;
  assign hist_entry_out = lookup_r;

  // read data selection
  wire logic [31:0] idx_rd = {err_tag_r, row_r, quad_r, 3'h0}; // half bit reads zero
  wire logic [31:0] tag_rd = arr_ok ? tag_arr[row_r] : 32'h0;
  wire logic [31:0] lo_rd = arr_ok ? data_arr[quad_idx][31:0] : 32'h0;
  wire logic [31:0] data_rd = half_r ? rd_hi_r : lo_rd;
  wire logic [31:0] csr_rd = {31'h0, enable_r};
  wire logic [31:0] br_rd = {alg_r, 10'h0, mispredict_r, 1'h0, hist_r[ctr_r]};
  wire logic [31:0] rd_mux = hit_idx ? idx_rd :
                             hit_tag ? tag_rd :
                             hit_data ? data_rd :
                             hit_csr ? csr_rd :
                             hit_br ? br_rd : 32'h0;

  // answer one cycle after every request, unmapped reads return zero
  logic ack_r;
  logic [31:0] rdata_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_r <= 1'h0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= ipr_req_in;
      rdata_r <= rd ? rd_mux : 32'h0;
    end
  end
  assign ipr_ack_out = ack_r;
  assign ipr_rdata_out = rdata_r;

  // checks: the shadow below mirrors only what software wrote, so a fill buffer
  // that picked up the wrong word shows up as a commit mismatch
  // rather than passing silently
  logic [31:0] chk_lo_r; // last low half written over the register path
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      chk_lo_r <= 32'h0;
    end else if (wr && hit_data && !half_r) begin
      chk_lo_r <= ipr_wdata_in;
    end
  end

  sequence s_lo_fill;
    wr_data && !half_r && arr_ok;
  endsequence
  sequence s_hi_commit;
    wr_data && half_r && arr_ok;
  endsequence

  AST_ERR_TAG: assert property (@(posedge clk_in) disable iff (reset_in)
    parity_err_in |=> err_tag_r == $past(parity_err_vaddr_in[31:11]))
    else $error("error tag not captured");
  AST_ERR_ROW: assert property (@(posedge clk_in) disable iff (reset_in)
    parity_err_in |=> row_r == $past(parity_err_vaddr_in[10:5]))
    else $error("error row not captured");
  AST_ERR_QUAD: assert property (@(posedge clk_in) disable iff (reset_in)
    parity_err_in |=> quad_r == $past(parity_err_vaddr_in[4:3]))
    else $error("error quadword not captured");
  AST_QUAD_COMMIT: assert property (@(posedge clk_in) disable iff (reset_in)
    s_hi_commit |=> data_arr[$past(quad_idx)] == {$past(ipr_wdata_in), $past(chk_lo_r)})
    else $error("quadword commit wrong");
  AST_LO_FILL: assert property (@(posedge clk_in) disable iff (reset_in)
    s_lo_fill |=> fill_lo_r == $past(ipr_wdata_in))
    else $error("low half not buffered");
  AST_ALG_LOAD: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_br |=> alg_r == $past(ipr_wdata_in[31:16]))
    else $error("algorithm not loaded");
  AST_PREDICT: assert property (@(posedge clk_in) disable iff (reset_in)
    !$past(reset_in) |-> predict_taken_out == $past(alg_r[branch_history_in]))
    else $error("prediction bit wrong");
  AST_FLUSH: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_br && br_cmd == 3'h1) |=> hist_r[$past(ctr_r)] == ibd_pkg::HIST_NEUTRAL && ctr_r == $past(ctr_r))
    else $error("flush failed");
  AST_CTR_CLEAR: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_br && br_cmd == 3'h2) |=> ctr_r == 9'h0)
    else $error("counter not cleared");
  AST_CTR_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_br |=> ctr_r == 9'($past(ctr_r) + 9'h1))
    else $error("counter did not step");
  AST_HIST_WRITE: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_br && br_cmd == 3'h4) |=> hist_r[$past(ctr_r)] == $past(ipr_wdata_in[3:0])
      && ctr_r == 9'($past(ctr_r) + 9'h1))
    else $error("history write wrong");
  AST_MISPREDICT: assert property (@(posedge clk_in) disable iff (reset_in)
    (branch_resolve_in ##1 !branch_resolve_in) |-> mispredict_r == $past(branch_mispredict_in))
    else $error("mispredict flag wrong");
  AST_HALF_READ: assert property (@(posedge clk_in) disable iff (reset_in)
    (rd_data && half_r) |=> ipr_ack_out && ipr_rdata_out == $past(rd_hi_r))
    else $error("upper half read wrong");
  AST_ENABLED_RD: assert property (@(posedge clk_in) disable iff (reset_in)
    (rd_data && !half_r && !arr_ok) |=> ipr_rdata_out == 32'h0)
    else $error("array read while enabled");
  AST_IDX_HALF_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
    (rd && hit_idx) |=> ipr_rdata_out[ibd_pkg::IDX_HALF_BIT] == 1'b0)
    else $error("half select bit readable");
endmodule : ibd_regs
`default_nettype wire

// ---- test/ibd_regs_test.sv ----
`default_nettype none
module ibd_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0; // core clock
  logic rst = 1'b1; // synchronous reset, high
  logic req = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] va = 32'h00000000; // faulting address on parity error
  logic [31:0] rdata;
  logic [31:0] rd_q; // read data captured with ack
  logic perr = 1'b0;
  logic res = 1'b0;
  logic misp = 1'b0;
  logic cflush = 1'b0;
  logic [3:0] bh = 4'h0;
  logic [8:0] hl = 9'h000; // lookup stays on entry 0
  logic ack;
  logic pred;
  logic en;
  logic [3:0] he;
  int bad_count = 0;
  int n_compared = 0;
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  ibd_regs i_dut (.clk_in(clk), .reset_in(rst), .ipr_req_in(req), .ipr_write_in(wr_en),
    .ipr_addr_in(addr), .ipr_wdata_in(wd), .ipr_ack_out(ack), .ipr_rdata_out(rdata),
    .parity_err_in(perr), .parity_err_vaddr_in(va), .icache_enable_out(en),
    .branch_history_in(bh), .predict_taken_out(pred), .branch_resolve_in(res),
    .branch_mispredict_in(misp), .context_flush_in(cflush), .hist_lookup_in(hl),
    .hist_entry_out(he));
  // four-state compare, counted
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one access: request over one rising edge, ack and data looked at one cycle later
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req = 1'b1;
    wr_en = w;
    addr = a;
    wd = d;
    @(negedge clk);
    req = 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
    rd_q = rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(nm, exp, rd_q);
  endtask
  // single place where the run ends
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the sequence needs about 4.6 us
  initial begin
    #40000;
    bad_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd("alg_reset", 8'hD4, 32'hFECA0004);
    rd("csr_reset", 8'hD3, 32'h0);
    wr(8'hD4, 32'h123400C0);
    for (int i = 0; i < 3; i++) begin
      wr(8'hD4, 32'h12340100 | i);
    end
    // command 000 must leave history alone
    wr(8'hD4, 32'h5A5A000F);
    wr(8'hD4, 32'h5A5A0080);
    for (int i = 0; i < 3; i++) begin
      rd("hist", 8'hD4, 32'h5A5A0000 | i);
    end
    wr(8'hD4, 32'h5A5A0040);
    wr(8'hD4, 32'h5A5A0080);
    rd("flushed", 8'hD4, 32'h5A5A0004);
    // wrap: 512 steps land back on entry 0
    wr(8'hD4, 32'h5A5A0080);
    wr(8'hD4, 32'h5A5A0109);
    for (int i = 0; i < 511; i++) begin
      acc(1'b0, 8'hD4, 32'h0);
    end
    rd("wrap", 8'hD4, 32'h5A5A0009);
    chk("lookup", 32'h9, {28'h0, he});
    @(negedge clk);
    cflush = 1'b1;
    @(negedge clk);
    cflush = 1'b0;
    @(negedge clk);
    chk("ctx_flush", 32'h4, {28'h0, he});
    // mispredict flag follows the last resolved branch
    @(negedge clk);
    res = 1'b1;
    misp = 1'b1;
    @(negedge clk);
    res = 1'b0;
    rd("misp1", 8'hD4, 32'h5A5A0024);
    @(negedge clk);
    res = 1'b1;
    misp = 1'b0;
    @(negedge clk);
    res = 1'b0;
    rd("misp0", 8'hD4, 32'h5A5A0004);
    // only history 0101 selects the set algorithm bit
    wr(8'hD4, 32'h00200000);
    for (int h = 0; h < 16; h++) begin
      bh = h[3:0];
      @(negedge clk);
      chk("predict", {31'h0, h == 5}, {31'h0, pred});
    end
    // array access only while disabled
    wr(8'hD0, 32'hFFFFFFFB);
    rd("index", 8'hD0, 32'h000007F8);
    wr(8'hD2, 32'h11111111);
    wr(8'hD0, 32'h000007FC);
    wr(8'hD2, 32'h22222222);
    wr(8'hD0, 32'h000007F8);
    wr(8'hD2, 32'h33333333);
    rd("data_lo", 8'hD2, 32'h11111111);
    wr(8'hD0, 32'h000007FC);
    rd("data_hi", 8'hD2, 32'h22222222);
    wr(8'hD1, 32'hFFFFFFFF);
    rd("tag", 8'hD1, 32'hFFFFF9FF);
    wr(8'hD3, 32'h1);
    chk("enable", 32'h1, {31'h0, en});
    // while enabled: the commit is dropped and a low read gives zero
    wr(8'hD2, 32'h44444444);
    wr(8'hD0, 32'h000007F8);
    rd("enabled_rd", 8'hD2, 32'h0);
    wr(8'hD3, 32'h0);
    rd("kept_lo", 8'hD2, 32'h11111111);
    rd("unmapped", 8'hD5, 32'h0);
    // parity error captures address bits 31:3
    @(negedge clk);
    perr = 1'b1;
    va = 32'hABCDE96D;
    @(negedge clk);
    perr = 1'b0;
    rd("err_addr", 8'hD0, 32'hABCDE968);
    // mid-run reset brings back the power-up state
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd("alg_rerst", 8'hD4, 32'hFECA0004);
    rd("idx_rerst", 8'hD0, 32'h0);
    chk("en_rerst", 32'h0, {31'h0, en});
    report_and_stop();
  end
endmodule // ibd_regs_test
`default_nettype wire
